// ==== design/lmcc_config_bank.sv ====
/*
 * Common configuration bank of an LED matrix driver with its serial link.
 * The link side runs on the controller's free-running serial clock; the
 * registers, decoded settings and memory-write counters run on core_clk.
 * Assumes the controller honours the frame format on sin.
 */
// Behaviour
// - Device count is code plus one, reset 8.
// - Pre-discharge enable bit 8, resets set.
// - Power saving enable bit 12, resets clear.
// - Two-bit enhanced power saving level, resets off.
// - Bit 15 enables open-load LED removal.
// - Scan lines are code plus one, reset 16.
// - Sub-periods are sixteen times code plus one.
// - Bit 27 picks multiplier low or high range.
// - Grayscale clock is serial clock times code+1.
// - Per-colour group delays in grayscale clocks, reset 0.
// - Module size picks stacking; single flags more than sixteen lines.
// - Segment length 1024 for 1023, else 128.
// - Line switch 45 for zero, else (code+1)*30.
// - Line counter steps per sixteen writes, wraps.
`timescale 1ns/100ps
`include "lmcc_consts.svh"

module lmcc_config_bank
   import lmcc_pkg::*;
#(
   parameter int CMD_W = `LMCC_CMD_W,
   parameter int REG_W = `LMCC_REG_W
) (
   // Core clock and reset.
   input wire logic core_clk,
   input wire logic rst_b,
   // Serial link.
   input wire logic sclk,
   input wire logic sin,
   output logic sout,
   // Decoded settings.
   output lmcc_cfg_t cfg,
   // Memory write port and frame events.
   output logic mem_wr_valid,
   output lmcc_mem_t mem_wr,
   output logic vsync_pulse
);

   typedef enum logic [3:0] {
      LMCC_ST_IDLE = 4'b0001,
      LMCC_ST_CMD = 4'b0010,
      LMCC_ST_WDATA = 4'b0100,
      LMCC_ST_RDATA = 4'b1000
   } lmcc_state_t;

   if (CMD_W != `LMCC_CMD_W || REG_W != `LMCC_REG_W) begin : g_bad_width
      $error("lmcc_config_bank: unsupported command or register width");
   end

   // Link side: reset and data synchronisers.
   logic srst_s1_q;
   logic srst_s2_q;
   logic sin_s1_q;
   logic sin_s2_q;

   always_ff @(posedge sclk) begin
      srst_s1_q <= rst_b;
      srst_s2_q <= srst_s1_q;
      sin_s1_q <= sin;
      sin_s2_q <= sin_s1_q;
   end

   // Link side: frame receiver and read shifter.
   lmcc_state_t st_q;
   logic [5:0] bit_cnt_q;
   logic [CMD_W-1:0] cmd_q;
   logic [REG_W-1:0] shift_q;
   logic [REG_W-1:0] rd_q;
   lmcc_op_t wop_q;
   lmcc_evt_t evt_q;
   logic evt_tgl_q;
   logic sout_q;
   logic [2*REG_W-1:0] shadow_q;
   logic [CMD_W-1:0] cmd_d;

   assign cmd_d = {cmd_q[CMD_W-2:0], sin_s2_q};
   assign sout = sout_q;

   always_ff @(posedge sclk) begin
      if (!srst_s2_q) begin
         st_q <= LMCC_ST_IDLE;
         bit_cnt_q <= 6'h00;
         cmd_q <= '0;
         shift_q <= '0;
         rd_q <= '0;
         wop_q <= LMCC_OP_WR_A;
         evt_q <= '0;
         evt_tgl_q <= 1'b0;
         sout_q <= 1'b1;
      end else begin
         unique case (st_q)
            LMCC_ST_IDLE: begin
               sout_q <= 1'b1;
               bit_cnt_q <= 6'h00;
               if (!sin_s2_q) begin
                  st_q <= LMCC_ST_CMD;
               end
            end
            LMCC_ST_CMD: begin
               cmd_q <= cmd_d;
               bit_cnt_q <= bit_cnt_q + 6'h01;
               if (bit_cnt_q == 6'(CMD_W - 1)) begin
                  bit_cnt_q <= 6'h00;
                  st_q <= LMCC_ST_IDLE;
                  unique case (cmd_d)
                     `LMCC_CMD_WR_A: begin
                        wop_q <= LMCC_OP_WR_A;
                        st_q <= LMCC_ST_WDATA;
                     end
                     `LMCC_CMD_WR_B: begin
                        wop_q <= LMCC_OP_WR_B;
                        st_q <= LMCC_ST_WDATA;
                     end
                     `LMCC_CMD_MEM: begin
                        wop_q <= LMCC_OP_MEM;
                        st_q <= LMCC_ST_WDATA;
                     end
                     `LMCC_CMD_RD_A: begin
                        rd_q <= shadow_q[REG_W-1:0];
                        st_q <= LMCC_ST_RDATA;
                     end
                     `LMCC_CMD_RD_B: begin
                        rd_q <= shadow_q[2*REG_W-1:REG_W];
                        st_q <= LMCC_ST_RDATA;
                     end
                     `LMCC_CMD_VSYNC: begin
                        evt_q <= '{op: LMCC_OP_VSYNC, data: '0};
                        evt_tgl_q <= ~evt_tgl_q;
                     end
                     `LMCC_CMD_SRST: begin
                        evt_q <= '{op: LMCC_OP_SRST, data: '0};
                        evt_tgl_q <= ~evt_tgl_q;
                     end
                     default: begin
                        st_q <= LMCC_ST_IDLE;
                     end
                  endcase
               end
            end
            LMCC_ST_WDATA: begin
               shift_q <= {shift_q[REG_W-2:0], sin_s2_q};
               bit_cnt_q <= bit_cnt_q + 6'h01;
               if (bit_cnt_q == 6'(REG_W - 1)) begin
                  evt_q <= '{op: wop_q, data: {shift_q[REG_W-2:0], sin_s2_q}};
                  evt_tgl_q <= ~evt_tgl_q;
                  st_q <= LMCC_ST_IDLE;
               end
            end
            LMCC_ST_RDATA: begin
               sout_q <= rd_q[REG_W-1];
               rd_q <= {rd_q[REG_W-2:0], 1'b0};
               bit_cnt_q <= bit_cnt_q + 6'h01;
               if (bit_cnt_q == 6'(REG_W - 1)) begin
                  st_q <= LMCC_ST_IDLE;
               end
            end
         endcase
      end
   end

   // Link side: mirror of the registers taken over by toggle handshake.
   logic mir_req_q;
   logic mreq_s1_q;
   logic mreq_s2_q;
   logic mack_q;
   logic [2*REG_W-1:0] mirror_q;

   always_ff @(posedge sclk) begin
      mreq_s1_q <= mir_req_q;
      mreq_s2_q <= mreq_s1_q;
   end

   always_ff @(posedge sclk) begin
      if (!srst_s2_q) begin
         mack_q <= 1'b0;
         shadow_q <= {`LMCC_B_RESET, `LMCC_A_RESET};
      end else if (mreq_s2_q != mack_q) begin
         shadow_q <= mirror_q;
         mack_q <= mreq_s2_q;
      end
   end

   // Core side: event crossing.
   logic evt_s1_q;
   logic evt_s2_q;
   logic evt_s3_q;
   logic evt_hit;

   always_ff @(posedge core_clk) begin
      evt_s1_q <= evt_tgl_q;
      evt_s2_q <= evt_s1_q;
      evt_s3_q <= evt_s2_q;
   end

   assign evt_hit = evt_s2_q != evt_s3_q;

   // Core side: the two configuration registers.
   logic [REG_W-1:0] cfg_a_q;
   logic [REG_W-1:0] cfg_b_q;

   always_ff @(posedge core_clk) begin
      if (!rst_b || (evt_hit && evt_q.op == LMCC_OP_SRST)) begin
         cfg_a_q <= `LMCC_A_RESET;
         cfg_b_q <= `LMCC_B_RESET;
      end else if (evt_hit && evt_q.op == LMCC_OP_WR_A) begin
         cfg_a_q <= (evt_q.data & `LMCC_A_WMASK) |
            (`LMCC_A_RESET & ~`LMCC_A_WMASK);
      end else if (evt_hit && evt_q.op == LMCC_OP_WR_B) begin
         cfg_b_q <= (evt_q.data & `LMCC_B_WMASK) |
            (`LMCC_B_RESET & ~`LMCC_B_WMASK);
      end
   end

   // Core side: publish the registers towards the link side.
   logic mack_s1_q;
   logic mack_s2_q;

   always_ff @(posedge core_clk) begin
      mack_s1_q <= mack_q;
      mack_s2_q <= mack_s1_q;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         mir_req_q <= 1'b0;
         mirror_q <= {`LMCC_B_RESET, `LMCC_A_RESET};
      end else if (mack_s2_q == mir_req_q) begin
         mirror_q <= {cfg_b_q, cfg_a_q};
         mir_req_q <= ~mir_req_q;
      end
   end

   // Core side: decoded settings.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cfg <= '0;
      end else begin
         cfg.device_count <= {1'b0, cfg_a_q[`LMCC_F_DEVCNT]} + 6'h01;
         cfg.predischarge_enable <= cfg_a_q[`LMCC_F_PDC];
         cfg.power_save_enable <= cfg_a_q[`LMCC_F_PS];
         cfg.power_save_plus_level <=
            lmcc_psp_t'(cfg_a_q[`LMCC_F_PSP]);
         cfg.open_load_removal_enable <= cfg_a_q[`LMCC_F_OLR];
         cfg.scan_lines <= {1'b0, cfg_a_q[`LMCC_F_SCAN]} + 6'h01;
         cfg.subperiod_count <=
            {({1'b0, cfg_a_q[`LMCC_F_SUBP]} + 4'h1), 4'h0};
         cfg.multiplier_range <= cfg_a_q[`LMCC_F_RANGE];
         cfg.multiplier_factor <=
            {1'b0, cfg_a_q[`LMCC_F_MULT]} + 5'h01;
         cfg.red_group_delay <= cfg_a_q[`LMCC_F_DLY_R];
         cfg.green_group_delay <= cfg_a_q[`LMCC_F_DLY_G];
         cfg.blue_group_delay <= cfg_a_q[`LMCC_F_DLY_B];
         cfg.stack_size <= cfg_a_q[`LMCC_F_STACK];
         unique case (cfg_a_q[`LMCC_F_STACK])
            2'h1: cfg.stacked_devices <= 2'h1;
            2'h3: cfg.stacked_devices <= 2'h3;
            default: cfg.stacked_devices <= 2'h2;
         endcase
         cfg.scan_limit_violation <= cfg_a_q[`LMCC_F_STACK] == 2'h1 &&
            cfg_a_q[`LMCC_F_SCAN] > `LMCC_SCAN_SINGLE_MAX;
         cfg.segment_length <=
            (cfg_b_q[`LMCC_F_SEG] == `LMCC_SEG_LONG_CODE) ?
            `LMCC_SEG_LONG : `LMCC_SEG_SHORT;
         cfg.line_switch_time <= (cfg_b_q[`LMCC_F_LSW] == 4'h0) ?
            `LMCC_LSW_ZERO :
            9'(({5'h00, cfg_b_q[`LMCC_F_LSW]} + 9'h001) *
            `LMCC_LSW_STEP);
      end
   end

   // Core side: memory write counters.
   logic [3:0] chan_q;
   logic [4:0] line_q;

   always_ff @(posedge core_clk) begin
      if (!rst_b || (evt_hit && evt_q.op == LMCC_OP_SRST)) begin
         chan_q <= 4'h0;
         line_q <= 5'h00;
      end else if (evt_hit && evt_q.op == LMCC_OP_VSYNC) begin
         chan_q <= 4'h0;
         line_q <= 5'h00;
      end else if (evt_hit && evt_q.op == LMCC_OP_MEM) begin
         chan_q <= chan_q + 4'h1;
         if (chan_q == `LMCC_CH_LAST) begin
            if (line_q >= cfg_a_q[`LMCC_F_SCAN]) begin
               line_q <= 5'h00;
            end else begin
               line_q <= line_q + 5'h01;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         mem_wr_valid <= 1'b0;
         mem_wr <= '0;
         vsync_pulse <= 1'b0;
      end else begin
         mem_wr_valid <= evt_hit && evt_q.op == LMCC_OP_MEM;
         vsync_pulse <= evt_hit && evt_q.op == LMCC_OP_VSYNC;
         if (evt_hit && evt_q.op == LMCC_OP_MEM) begin
            mem_wr <= '{line: line_q, channel: chan_q, data: evt_q.data};
         end
      end
   end

endmodule

// ==== design/lmcc_consts.svh ====
/*
 * Constants of the LED matrix common configuration bank: command codes,
 * register layout, reset values and link framing.
 * Assumes it is included by its bare name, once or more.
 */
`ifndef LMCC_CONSTS_SVH
`define LMCC_CONSTS_SVH

`define LMCC_CMD_W 16
`define LMCC_REG_W 48
`define LMCC_CNT_W 6

`define LMCC_CMD_WR_A 16'hAA00
`define LMCC_CMD_WR_B 16'hAA01
`define LMCC_CMD_RD_A 16'hAA60
`define LMCC_CMD_RD_B 16'hAA61
`define LMCC_CMD_MEM 16'hAA30
`define LMCC_CMD_VSYNC 16'hAAF0
`define LMCC_CMD_SRST 16'hAA80

`define LMCC_A_RESET 48'h1000_700F_0107
`define LMCC_A_WMASK 48'hCFF8_F8FF_F11F
`define LMCC_B_RESET 48'h00E0_0094_A400
`define LMCC_B_WMASK 48'h7FFF_FFFF_FFFF

`define LMCC_F_DEVCNT 4:0
`define LMCC_F_PDC 8
`define LMCC_F_PS 12
`define LMCC_F_PSP 14:13
`define LMCC_F_OLR 15
`define LMCC_F_SCAN 20:16
`define LMCC_F_SUBP 23:21
`define LMCC_F_RANGE 27
`define LMCC_F_MULT 31:28
`define LMCC_F_DLY_R 37:35
`define LMCC_F_DLY_G 40:38
`define LMCC_F_DLY_B 43:41
`define LMCC_F_STACK 47:46
`define LMCC_F_SEG 9:0
`define LMCC_F_LSW 40:37

`define LMCC_SEG_LONG_CODE 10'h3FF
`define LMCC_SEG_SHORT 11'h080
`define LMCC_SEG_LONG 11'h400
`define LMCC_LSW_ZERO 9'h02D
`define LMCC_LSW_STEP 9'h01E
`define LMCC_SCAN_SINGLE_MAX 5'h0F
`define LMCC_CH_LAST 4'hF

`endif

// ==== design/lmcc_pkg.sv ====
/*
 * Types of the LED matrix common configuration bank.
 * Assumes lmcc_consts.svh is reachable on the include path.
 */
`include "lmcc_consts.svh"

package lmcc_pkg;

   typedef enum logic [1:0] {
      LMCC_PSP_OFF = 2'h0,
      LMCC_PSP_HIGH = 2'h1,
      LMCC_PSP_MID = 2'h2,
      LMCC_PSP_LOW = 2'h3
   } lmcc_psp_t;

   typedef enum logic [2:0] {
      LMCC_OP_WR_A = 3'h0,
      LMCC_OP_WR_B = 3'h1,
      LMCC_OP_MEM = 3'h2,
      LMCC_OP_VSYNC = 3'h3,
      LMCC_OP_SRST = 3'h4
   } lmcc_op_t;

   typedef struct packed {
      lmcc_op_t op;
      logic [`LMCC_REG_W-1:0] data;
   } lmcc_evt_t;

   typedef struct packed {
      logic [5:0] device_count;
      logic predischarge_enable;
      logic power_save_enable;
      lmcc_psp_t power_save_plus_level;
      logic open_load_removal_enable;
      logic [5:0] scan_lines;
      logic [7:0] subperiod_count;
      logic multiplier_range;
      logic [4:0] multiplier_factor;
      logic [2:0] red_group_delay;
      logic [2:0] green_group_delay;
      logic [2:0] blue_group_delay;
      logic [1:0] stack_size;
      logic [1:0] stacked_devices;
      logic scan_limit_violation;
      logic [10:0] segment_length;
      logic [8:0] line_switch_time;
   } lmcc_cfg_t;

   typedef struct packed {
      logic [4:0] line;
      logic [3:0] channel;
      logic [`LMCC_REG_W-1:0] data;
   } lmcc_mem_t;

endpackage

// ==== bench/lmcc_monitor.sv ====
/* Checker for the configuration bank outputs.
   Assumes it is bound to lmcc_config_bank. */
`timescale 1ns/100ps
module lmcc_monitor
   import lmcc_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_b,
   // Watched outputs.
   input wire lmcc_cfg_t cfg,
   input wire logic mem_wr_valid,
   input wire lmcc_mem_t mem_wr,
   input wire logic vsync_pulse
);
   logic [1:0] rdy_q;
   logic seen_q;
   logic [3:0] ch_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Decoded settings are meaningful one edge after reset; the checks wait two edges.
   always_ff @(posedge core_clk) begin
      rdy_q <= rst_b ? {rdy_q[0], 1'b1} : 2'h0;
   end
   always_ff @(posedge core_clk) begin
      if (!rst_b || vsync_pulse) begin
         seen_q <= 1'b0;
      end else if (mem_wr_valid) begin
         seen_q <= 1'b1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (mem_wr_valid) begin
         ch_q <= mem_wr.channel;
      end
   end
   property p_devcnt;
      rdy_q[1] |-> cfg.device_count inside {[6'h01:6'h20]};
   endproperty
   a_devcnt: assert property (p_devcnt)
      else $error("device count out of range");
   property p_scan;
      rdy_q[1] |-> cfg.scan_lines inside {[6'h01:6'h20]};
   endproperty
   a_scan: assert property (p_scan)
      else $error("scan lines out of range");
   property p_subp;
      rdy_q[1] |-> cfg.subperiod_count[3:0] == 4'h0 &&
         cfg.subperiod_count inside {[8'h10:8'h80]};
   endproperty
   a_subp: assert property (p_subp)
      else $error("sub-period count not a step of sixteen");
   property p_mult;
      rdy_q[1] |-> cfg.multiplier_factor inside {[5'h01:5'h10]};
   endproperty
   a_mult: assert property (p_mult)
      else $error("multiplier factor out of range");
   property p_stack;
      rdy_q[1] |-> cfg.stacked_devices == (cfg.stack_size == 2'h1 ? 2'h1 :
         cfg.stack_size == 2'h3 ? 2'h3 : 2'h2);
   endproperty
   a_stack: assert property (p_stack)
      else $error("stacked device count wrong");
   property p_viol;
      rdy_q[1] |-> cfg.scan_limit_violation ==
         (cfg.stack_size == 2'h1 && cfg.scan_lines > 6'h10);
   endproperty
   a_viol: assert property (p_viol)
      else $error("scan limit flag wrong");
   property p_seg;
      rdy_q[1] |-> cfg.segment_length inside {11'h080, 11'h400};
   endproperty
   a_seg: assert property (p_seg)
      else $error("segment length illegal");
   property p_lsw;
      rdy_q[1] |-> cfg.line_switch_time == 9'h02D ||
         (cfg.line_switch_time % 9'h01E == 9'h000 &&
         cfg.line_switch_time inside {[9'h03C:9'h1E0]});
   endproperty
   a_lsw: assert property (p_lsw)
      else $error("line switch time illegal");
   property p_chan;
      mem_wr_valid && seen_q |-> mem_wr.channel == ch_q + 4'h1;
   endproperty
   a_chan: assert property (p_chan)
      else $error("channel did not step by one");
   property p_pulse;
      mem_wr_valid |=> !mem_wr_valid;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("memory write pulse too long");
endmodule

bind lmcc_config_bank lmcc_monitor mon_u (
   .core_clk(core_clk),
   .rst_b(rst_b),
   .cfg(cfg),
   .mem_wr_valid(mem_wr_valid),
   .mem_wr(mem_wr),
   .vsync_pulse(vsync_pulse)
);

// ==== bench/lmcc_ctrl_model.sv ====
/* Display controller model on the serial link.
   Assumes a free-running sclk from the bench. */
`timescale 1ns/100ps
module lmcc_ctrl_model (
   // Link.
   input wire logic sclk,
   output logic sin,
   input wire logic sout
);
   initial sin = 1'b1;
   // Start bit, command, then data when w is set; idle high after.
   task automatic frame(input logic [15:0] c, input logic [47:0] d,
      input logic w);
      logic [63:0] f;
      f = {c, d};
      @(posedge sclk) sin <= 1'b0;
      for (int i = 63; i >= (w ? 0 : 48); i--) begin
         @(posedge sclk) sin <= f[i];
      end
      @(posedge sclk) sin <= 1'b1;
   endtask
   // Reply bit 47 stands after the third edge past the frame's end.
   // Each reply bit is taken at a falling edge, in the middle of its cell.
   task automatic read(input logic [15:0] c, output logic [47:0] d);
      frame(c, 48'h0, 1'b0);
      repeat (3) @(posedge sclk);
      for (int i = 47; i >= 0; i--) begin
         @(negedge sclk);
         d[i] = sout;
      end
   endtask
endmodule

// ==== bench/lmcc_config_bank_tb_top.sv ====
/* Bench of the configuration bank.
   Assumes the controller model and the bound checker. */
`timescale 1ns/100ps
`include "lmcc_consts.svh"
module lmcc_config_bank_tb_top
   import lmcc_pkg::*;
;
   logic core_clk;
   logic rst_b;
   logic sclk;
   logic sin;
   logic sout;
   lmcc_cfg_t cfg;
   logic mem_wr_valid;
   lmcc_mem_t mem_wr;
   logic vsync_pulse;
   int n_errors = 0;
   int checks = 0;
   lmcc_config_bank dut_u (.core_clk(core_clk), .rst_b(rst_b),
      .sclk(sclk), .sin(sin), .sout(sout), .cfg(cfg),
      .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr),
      .vsync_pulse(vsync_pulse));
   lmcc_ctrl_model ctl_u (.sclk(sclk), .sin(sin), .sout(sout));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      sclk = 1'b0;
      #13;
      forever #32 sclk = ~sclk;
   end
   task automatic conclude();
      if (n_errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string s, input logic [79:0] v,
      input logic [79:0] e);
      checks++;
      if (v !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, v);
      end
   endtask
   function automatic lmcc_cfg_t exp_cfg(logic [47:0] a, logic [47:0] b);
      lmcc_cfg_t e;
      e.device_count = {1'b0, a[4:0]} + 6'h01;
      e.predischarge_enable = a[8];
      e.power_save_enable = a[12];
      e.power_save_plus_level = lmcc_psp_t'(a[14:13]);
      e.open_load_removal_enable = a[15];
      e.scan_lines = {1'b0, a[20:16]} + 6'h01;
      e.subperiod_count = {1'b0, a[23:21], 4'h0} + 8'h10;
      e.multiplier_range = a[27];
      e.multiplier_factor = {1'b0, a[31:28]} + 5'h01;
      e.red_group_delay = a[37:35];
      e.green_group_delay = a[40:38];
      e.blue_group_delay = a[43:41];
      e.stack_size = a[47:46];
      e.stacked_devices = a[47:46] == 2'h1 ? 2'h1 :
         (a[47:46] == 2'h3 ? 2'h3 : 2'h2);
      e.scan_limit_violation = a[47:46] == 2'h1 && a[20:16] > 5'h0F;
      e.segment_length = b[9:0] == 10'h3FF ? 11'h400 : 11'h080;
      e.line_switch_time = b[40:37] == 4'h0 ? 9'h02D :
         ({5'h00, b[40:37]} + 9'h001) * 9'h01E;
      return e;
   endfunction
   task automatic wr(input logic [15:0] c, input logic [47:0] d,
      input logic w);
      ctl_u.frame(c, d, w);
      repeat (10) @(posedge sclk);
   endtask
   task automatic rd(input logic [15:0] c, input logic [47:0] e);
      logic [47:0] v;
      ctl_u.read(c, v);
      repeat (4) @(posedge sclk);
      check("register", {32'h0, v}, {32'h0, e});
   endtask
   task automatic pulse(input logic sel);
      int n;
      n = 0;
      while ((sel ? mem_wr_valid : vsync_pulse) !== 1'b1 && n < 3000) begin
         @(negedge core_clk);
         n++;
      end
      check("pulse", {79'h0, n < 3000}, 80'h1);
   endtask
   task automatic settings(input logic [47:0] a, input logic [47:0] b);
      lmcc_cfg_t g;
      lmcc_cfg_t e;
      g = cfg;
      e = exp_cfg(a, b);
      check("device_count", 80'(g.device_count),
         80'(e.device_count));
      check("predischarge", 80'(g.predischarge_enable),
         80'(e.predischarge_enable));
      check("power_save", 80'(g.power_save_enable),
         80'(e.power_save_enable));
      check("power_save_plus", 80'(g.power_save_plus_level),
         80'(e.power_save_plus_level));
      check("open_load", 80'(g.open_load_removal_enable),
         80'(e.open_load_removal_enable));
      check("scan_lines", 80'(g.scan_lines), 80'(e.scan_lines));
      check("subperiods", 80'(g.subperiod_count),
         80'(e.subperiod_count));
      check("mult_range", 80'(g.multiplier_range),
         80'(e.multiplier_range));
      check("mult_factor", 80'(g.multiplier_factor),
         80'(e.multiplier_factor));
      check("red_delay", 80'(g.red_group_delay),
         80'(e.red_group_delay));
      check("green_delay", 80'(g.green_group_delay),
         80'(e.green_group_delay));
      check("blue_delay", 80'(g.blue_group_delay),
         80'(e.blue_group_delay));
      check("stack", 80'({g.stack_size, g.stacked_devices}),
         80'({e.stack_size, e.stacked_devices}));
      check("scan_limit", 80'(g.scan_limit_violation),
         80'(e.scan_limit_violation));
      check("segment", 80'(g.segment_length),
         80'(e.segment_length));
      check("line_switch", 80'(g.line_switch_time),
         80'(e.line_switch_time));
   endtask
   task automatic t_defaults();
      settings(`LMCC_A_RESET, `LMCC_B_RESET);
      rd(16'hAA60, `LMCC_A_RESET);
      rd(16'hAA61, `LMCC_B_RESET);
   endtask
   task automatic t_regs();
      logic [47:0] va [4] = '{48'h0, 48'hFFFF_FFFF_FFFF,
         48'h4000_000F_2000, 48'h8000_0000_4000};
      logic [47:0] vb [4] = '{48'h0, 48'h7FFF_FFFF_FFFF,
         48'h0020_0000_007F, 48'h8000_0000_03FE};
      logic [47:0] ea;
      logic [47:0] eb;
      for (int i = 0; i < 4; i++) begin
         ea = (va[i] & `LMCC_A_WMASK) | (`LMCC_A_RESET & ~`LMCC_A_WMASK);
         eb = (vb[i] & `LMCC_B_WMASK) | (`LMCC_B_RESET & ~`LMCC_B_WMASK);
         wr(16'hAA00, va[i], 1'b1);
         wr(16'hAA01, vb[i], 1'b1);
         settings(ea, eb);
         rd(16'hAA60, ea);
         rd(16'hAA61, eb);
      end
   endtask
   task automatic mem(input int i, input logic [4:0] ln,
      input logic [3:0] ch);
      logic [47:0] d;
      d = 48'hC0DE_0000_0000 + 48'(i);
      fork
         ctl_u.frame(16'hAA30, d, 1'b1);
         pulse(1'b1);
      join
      check("mem", {23'h0, mem_wr}, {23'h0, ln, ch, d});
      repeat (6) @(posedge sclk);
   endtask
   task automatic t_mem();
      logic [47:0] a;
      a = `LMCC_A_RESET;
      a[20:16] = 5'h01;
      wr(16'hAA00, a, 1'b1);
      fork
         wr(16'hAAF0, 48'h0, 1'b0);
         pulse(1'b0);
      join
      for (int i = 0; i < 33; i++) begin
         mem(i, 5'((i / 16) % 2), 4'(i % 16));
      end
      fork
         wr(16'hAAF0, 48'h0, 1'b0);
         pulse(1'b0);
      join
      mem(33, 5'h00, 4'h0);
   endtask
   task automatic t_srst();
      wr(16'hAA00, 48'h0, 1'b1);
      wr(16'hAA05, 48'h0, 1'b0);
      rd(16'hAA60, 48'h1000_0000_0000);
      wr(16'hAA80, 48'h0, 1'b0);
      t_defaults();
   endtask
   initial begin
      repeat (90000) @(posedge core_clk);
      n_errors++;
      conclude();
   end
   initial begin
      rst_b = 1'b0;
      repeat (4) @(posedge sclk);
      @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sclk);
      t_defaults();
      t_regs();
      t_mem();
      t_srst();
      conclude();
   end
endmodule
